/* cpuoa_defs.svh */
`ifndef CPUOA_DEFS_SVH
`define CPUOA_DEFS_SVH

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define CPUOA_OFS_INSTR   12'h000
`define CPUOA_OFS_STATUS  12'h004
`define CPUOA_OFS_PCH     12'h008
`define CPUOA_OFS_PCL     12'h00C
`define CPUOA_OFS_ACC     12'h010
`define CPUOA_OFS_IDX     12'h014
`define CPUOA_OFS_SP      12'h018
`define CPUOA_OFS_FLAGS   12'h01C

// ****************************************************************
// Reset values
// ****************************************************************
`define CPUOA_RST_BYTE    8'h00
`define CPUOA_RST_FLAGS   8'h02
`define CPUOA_RST_INSTR   16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define CPUOA_OPC_OP_HI   7
`define CPUOA_OPC_OP_LO   5
`define CPUOA_OPC_MD_HI   4
`define CPUOA_OPC_MD_LO   3
`define CPUOA_OPC_SPACE   2
`define CPUOA_OPC_RS_HI   1
`define CPUOA_OPC_RS_LO   0
`define CPUOA_F_ZERO      1
`define CPUOA_F_CARRY     2
`define CPUOA_F_SUPER     3
`define CPUOA_F_BANK      4
`define CPUOA_F_WMASK     8'h17
`define CPUOA_ST_BUSY     0
`define CPUOA_ST_ERR      1

// ****************************************************************
// Instruction length in bytes
// ****************************************************************
`define CPUOA_INSTR_LEN   16'h0002

`endif

/* cpuoa_pkg.sv */
package cpuoa_pkg;

  typedef enum logic [1:0] {
    CPUOA_IDLE = 2'b00,
    CPUOA_READ = 2'b01,
    CPUOA_EXEC = 2'b10
  } cpuoa_state_t;

  typedef enum logic [2:0] {
    CPUOA_MOV = 3'b000,
    CPUOA_ADD = 3'b001,
    CPUOA_SUB = 3'b010,
    CPUOA_AND = 3'b011,
    CPUOA_OR  = 3'b100,
    CPUOA_XOR = 3'b101
  } cpuoa_op_t;

  typedef enum logic [1:0] {
    CPUOA_SRC_IMM = 2'b00,
    CPUOA_SRC_DIR = 2'b01,
    CPUOA_SRC_IDX = 2'b10,
    CPUOA_DST_DIR = 2'b11
  } cpuoa_mode_t;

  typedef enum logic [1:0] {
    CPUOA_R_A  = 2'b00,
    CPUOA_R_X  = 2'b01,
    CPUOA_R_SP = 2'b10,
    CPUOA_R_F  = 2'b11
  } cpuoa_rsel_t;

endpackage

/* cpuoa_alu.sv */
`timescale 1ns/1ps
module cpuoa_alu (
  // Operation
  input  wire logic [2:0] op,
  input  wire logic [7:0] src,
  input  wire logic [7:0] second,
  // Result
  output logic      [7:0] result,
  output logic            carry,
  output logic            legal
);

  logic [8:0] sum;

  always_comb begin
    sum    = 9'h000;
    result = 8'h00;
    carry  = 1'b0;
    legal  = 1'b1;
    case (op)
      cpuoa_pkg::CPUOA_MOV: begin
        result = src;
      end
      cpuoa_pkg::CPUOA_ADD: begin
        sum    = {1'b0, second} + {1'b0, src};
        result = sum[7:0];
        carry  = sum[8];
      end
      cpuoa_pkg::CPUOA_SUB: begin
        // Borrow shows as carry
        sum    = {1'b0, second} - {1'b0, src};
        result = sum[7:0];
        carry  = sum[8];
      end
      cpuoa_pkg::CPUOA_AND: begin
        result = second & src;
      end
      cpuoa_pkg::CPUOA_OR: begin
        result = second | src;
      end
      cpuoa_pkg::CPUOA_XOR: begin
        result = second ^ src;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

endmodule

/* cpuoa_data_mem.sv */
`timescale 1ns/1ps
module cpuoa_data_mem (
  // Clock
  input  wire logic       pclk,
  // Access
  input  wire logic       rd_en,
  input  wire logic       wr_en,
  input  wire logic       space,
  input  wire logic       bank,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  // Read data, valid the cycle after rd_en
  output logic      [7:0] rdata_q
);

  logic [7:0] ram_mem [0:255];
  logic [7:0] reg_mem [0:511];

  always_ff @(posedge pclk) begin
    if (wr_en && !space) begin
      ram_mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_en && space) begin
      reg_mem[{bank, addr}] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    if (rd_en) begin
      rdata_q <= space ? reg_mem[{bank, addr}] : ram_mem[addr];
    end
  end

endmodule

/* cpuoa_core.sv */
`timescale 1ns/1ps
`include "cpuoa_defs.svh"
module cpuoa_core (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status
  output logic             busy
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cpuoa_pkg::cpuoa_state_t state_q;
  cpuoa_pkg::cpuoa_state_t state_d;

  logic [7:0]  pch_q;
  logic [7:0]  pcl_q;
  logic [7:0]  acc_q;
  logic [7:0]  idx_q;
  logic [7:0]  sp_q;
  logic [7:0]  flags_q;
  logic [7:0]  opcode_q;
  logic [7:0]  operand_q;
  logic        err_q;
  logic        busy_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  logic        apb_access;
  logic        apb_done;
  logic        apb_wr;
  logic        apb_rd;
  logic        mapped;
  logic        instr_wr;
  logic        instr_refused;
  logic [31:0] rd_word;

  logic [2:0]  op;
  logic [1:0]  mode;
  logic        space;
  logic [1:0]  rsel;
  logic [7:0]  eff_addr;
  logic [7:0]  reg_val;
  logic [7:0]  alu_src;
  logic [7:0]  alu_second;
  logic [7:0]  alu_result;
  logic        alu_carry;
  logic        alu_legal;
  logic [7:0]  mem_rdata;
  logic        mem_rd;
  logic        mem_wr;
  logic        exec;
  logic        to_mem;
  logic [15:0] pc_next;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      `CPUOA_OFS_INSTR, `CPUOA_OFS_STATUS, `CPUOA_OFS_PCH,
      `CPUOA_OFS_PCL, `CPUOA_OFS_ACC, `CPUOA_OFS_IDX,
      `CPUOA_OFS_SP, `CPUOA_OFS_FLAGS: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  // Non-immediate modes only reach A or X
  function automatic logic [1:0] reg_select(input logic [1:0] md,
                                            input logic [1:0] rs);
    if (md == cpuoa_pkg::CPUOA_SRC_IMM) begin
      reg_select = rs;
    end else begin
      reg_select = {1'b0, rs[0]};
    end
  endfunction

  function automatic logic [7:0] reg_read(input logic [1:0] rs,
                                          input logic [7:0] a,
                                          input logic [7:0] x,
                                          input logic [7:0] s,
                                          input logic [7:0] f);
    case (rs)
      cpuoa_pkg::CPUOA_R_A:  reg_read = a;
      cpuoa_pkg::CPUOA_R_X:  reg_read = x;
      cpuoa_pkg::CPUOA_R_SP: reg_read = s;
      default:               reg_read = f;
    endcase
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // One wait state: pready rises in the second access cycle
  assign apb_access = psel && penable;
  assign apb_done   = apb_access && pready_q;
  assign apb_wr     = apb_done && pwrite;
  assign apb_rd     = apb_access && !pready_q && !pwrite;
  assign mapped     = is_mapped(paddr);
  // Refusal was decided in the first access cycle; honour it here too
  assign instr_wr   = apb_wr && (paddr == `CPUOA_OFS_INSTR) && !busy_q &&
                      !pslverr_q;
  // A new instruction while one runs would corrupt the operand latch
  assign instr_refused = pwrite && (paddr == `CPUOA_OFS_INSTR) && busy_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `CPUOA_OFS_INSTR:  rd_word = {16'h0000, opcode_q, operand_q};
      `CPUOA_OFS_STATUS: rd_word = {30'h0000_0000, err_q, busy_q};
      `CPUOA_OFS_PCH:    rd_word = {24'h00_0000, pch_q};
      `CPUOA_OFS_PCL:    rd_word = {24'h00_0000, pcl_q};
      `CPUOA_OFS_ACC:    rd_word = {24'h00_0000, acc_q};
      `CPUOA_OFS_IDX:    rd_word = {24'h00_0000, idx_q};
      `CPUOA_OFS_SP:     rd_word = {24'h00_0000, sp_q};
      `CPUOA_OFS_FLAGS:  rd_word = {24'h00_0000, flags_q};
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= apb_access && !pready_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (apb_access && !pready_q) begin
      pslverr_q <= !mapped || instr_refused;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata_q <= rd_word;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign busy    = busy_q;

  // ****************************************************************
  // Instruction latch and decode
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_q  <= `CPUOA_RST_BYTE;
      operand_q <= `CPUOA_RST_BYTE;
    end else if (instr_wr) begin
      opcode_q  <= pwdata[15:8];
      operand_q <= pwdata[7:0];
    end
  end

  assign op    = opcode_q[`CPUOA_OPC_OP_HI:`CPUOA_OPC_OP_LO];
  assign mode  = opcode_q[`CPUOA_OPC_MD_HI:`CPUOA_OPC_MD_LO];
  assign space = opcode_q[`CPUOA_OPC_SPACE];
  assign rsel  = reg_select(mode,
                            opcode_q[`CPUOA_OPC_RS_HI:`CPUOA_OPC_RS_LO]);

  // Indexed sum wraps inside the selected space
  assign eff_addr = (mode == cpuoa_pkg::CPUOA_SRC_IDX) ?
                    8'(operand_q + idx_q) : operand_q;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      cpuoa_pkg::CPUOA_IDLE: begin
        if (instr_wr) begin
          state_d = cpuoa_pkg::CPUOA_READ;
        end
      end
      cpuoa_pkg::CPUOA_READ: begin
        state_d = cpuoa_pkg::CPUOA_EXEC;
      end
      cpuoa_pkg::CPUOA_EXEC: begin
        state_d = cpuoa_pkg::CPUOA_IDLE;
      end
      default: begin
        state_d = cpuoa_pkg::CPUOA_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cpuoa_pkg::CPUOA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != cpuoa_pkg::CPUOA_IDLE);
    end
  end

  assign exec   = (state_q == cpuoa_pkg::CPUOA_EXEC);
  assign to_mem = (mode == cpuoa_pkg::CPUOA_DST_DIR);
  assign mem_rd = (state_q == cpuoa_pkg::CPUOA_READ) &&
                  (mode != cpuoa_pkg::CPUOA_SRC_IMM);
  assign mem_wr = exec && to_mem && alu_legal;

  // ****************************************************************
  // Operand routing
  // ****************************************************************
  assign reg_val = reg_read(rsel, acc_q, idx_q, sp_q, flags_q);

  always_comb begin
    alu_src    = operand_q;
    alu_second = reg_val;
    case (mode)
      cpuoa_pkg::CPUOA_SRC_IMM: begin
        alu_src    = operand_q;
        alu_second = reg_val;
      end
      cpuoa_pkg::CPUOA_SRC_DIR, cpuoa_pkg::CPUOA_SRC_IDX: begin
        alu_src    = mem_rdata;
        alu_second = reg_val;
      end
      cpuoa_pkg::CPUOA_DST_DIR: begin
        alu_src    = reg_val;
        alu_second = mem_rdata;
      end
      default: begin
        alu_src    = operand_q;
        alu_second = reg_val;
      end
    endcase
  end

  cpuoa_alu u_alu (
    .op     (op),
    .src    (alu_src),
    .second (alu_second),
    .result (alu_result),
    .carry  (alu_carry),
    .legal  (alu_legal)
  );

  cpuoa_data_mem u_mem (
    .pclk    (pclk),
    .rd_en   (mem_rd),
    .wr_en   (mem_wr),
    .space   (space),
    .bank    (flags_q[`CPUOA_F_BANK]),
    .addr    (eff_addr),
    .wdata   (alu_result),
    .rdata_q (mem_rdata)
  );

  // ****************************************************************
  // Working registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= `CPUOA_RST_BYTE;
    end else if (exec && alu_legal && !to_mem &&
                 rsel == cpuoa_pkg::CPUOA_R_A) begin
      acc_q <= alu_result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= `CPUOA_RST_BYTE;
    end else if (exec && alu_legal && !to_mem &&
                 rsel == cpuoa_pkg::CPUOA_R_X) begin
      idx_q <= alu_result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= `CPUOA_RST_BYTE;
    end else if (exec && alu_legal && !to_mem &&
                 rsel == cpuoa_pkg::CPUOA_R_SP) begin
      sp_q <= alu_result;
    end
  end

  // Supervisor bit is never writable; reserved bits 7:5 stay zero, bit 0 is writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `CPUOA_RST_FLAGS;
    end else if (exec && alu_legal) begin
      if (!to_mem && rsel == cpuoa_pkg::CPUOA_R_F) begin
        flags_q <= (alu_result & `CPUOA_F_WMASK) |
                   (flags_q & ~`CPUOA_F_WMASK);
      end else if (op != cpuoa_pkg::CPUOA_MOV) begin
        flags_q[`CPUOA_F_ZERO]  <= (alu_result == 8'h00);
        flags_q[`CPUOA_F_CARRY] <= alu_carry;
      end
    end
  end

  // ****************************************************************
  // Error flag
  // ****************************************************************
  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (exec && !alu_legal) begin
      err_q <= 1'b1;
    end else if (apb_wr && paddr == `CPUOA_OFS_STATUS &&
                 pwdata[`CPUOA_ST_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************
  // Full 16-bit counter, no page logic
  assign pc_next = {pch_q, pcl_q} + `CPUOA_INSTR_LEN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pch_q <= `CPUOA_RST_BYTE;
    end else if (exec) begin
      pch_q <= pc_next[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcl_q <= `CPUOA_RST_BYTE;
    end else if (exec) begin
      pcl_q <= pc_next[7:0];
    end
  end

endmodule

/* cpuoa_core_props.sv */
`timescale 1ns/1ps
`include "cpuoa_defs.svh"
module cpuoa_core_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic done;
  logic go;
  assign done = psel && penable && pready;
  assign go   = done && pwrite && paddr == `CPUOA_OFS_INSTR;
  // ****************************************************************
  // Bus and execution timing
  // ****************************************************************
  property p_wait; $rose(psel && penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait)
    else $error("pready not after one wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse)
    else $error("pready longer than one cycle");
  property p_erq; pslverr |-> pready; endproperty
  a_erq: assert property (p_erq)
    else $error("pslverr without pready");
  // Two busy cycles: fetch of the operand byte, then writeback
  property p_run; go && !busy && !pslverr |=> busy [*2] ##1 !busy; endproperty
  a_run: assert property (p_run)
    else $error("instruction not two busy cycles");
  property p_cause; $rose(busy) |-> $past(go); endproperty
  a_cause: assert property (p_cause)
    else $error("busy without instruction write");
  property p_unmap;
    done && paddr > `CPUOA_OFS_FLAGS |-> pslverr && (pwrite || prdata == 0);
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped access not refused");
  property p_pch; done && !pwrite && paddr == `CPUOA_OFS_PCH
    |-> prdata[31:8] == 24'h000000; endproperty
  a_pch: assert property (p_pch)
    else $error("high byte read has upper bits set");
  property p_pcl; done && !pwrite && paddr == `CPUOA_OFS_PCL
    |-> prdata[31:8] == 24'h000000; endproperty
  a_pcl: assert property (p_pcl)
    else $error("low byte read has upper bits set");
  c_run: cover property (go && !busy);
  c_unmap: cover property (done && pslverr);
  c_busy: cover property (busy ##1 busy ##1 !busy);
endmodule
bind cpuoa_core cpuoa_core_props i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy));

/* cpu_operand_addressing_tb_top.sv */
`timescale 1ns/1ps
`include "cpuoa_defs.svh"
module cpu_operand_addressing_tb_top;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} cpuoa_exp_t;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  cpuoa_exp_t  q[$];
  cpuoa_exp_t  t;
  logic [7:0]  a, x, s, f;
  logic [7:0]  mem [0:767];
  logic [15:0] pc;
  logic [15:0] prog [21] = '{16'h005A, 16'h01C3, 16'h0277, 16'h8310,
    16'h1C40, 16'h1940, 16'hA314, 16'h1D40, 16'h0C40, 16'h8310, 16'h0D40,
    16'h63EF, 16'h3840, 16'h2840, 16'h01F0, 16'h5050, 16'h3550, 16'h2244,
    16'h4109, 16'h03FF, 16'h6300};
  logic [1:0]  r;

  always #5 pclk = ~pclk;

  cpuoa_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    check(32'(q.size()), 32'h0);
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    q.push_back('{d & m, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ****************************************************************
  // Reference model
  // ****************************************************************
  function automatic logic [7:0] rget(input logic [1:0] k);
    case (k)
      2'd0: return a;
      2'd1: return x;
      2'd2: return s;
      default: return f;
    endcase
  endfunction

  task automatic regs;
    logic [7:0] v [6];
    v = '{pc[15:8], pc[7:0], a, x, s, f};
    for (int i = 0; i < 6; i++)
      apb(1'b0, 12'(`CPUOA_OFS_PCH + 4 * i), {24'h0, v[i]}, 32'hFFFFFFFF,
          1'b0);
  endtask

  task automatic run(input logic [7:0] oc, input logic [7:0] od);
    logic [1:0] md, k;
    logic [7:0] ad, src, sec;
    logic [8:0] res;
    int         mi;
    md = oc[4:3];
    k = (md == 2'd0) ? oc[1:0] : {1'b0, oc[0]};
    ad = (md == 2'd2) ? od + x : od;
    mi = oc[2] ? (f[4] ? 512 : 256) + ad : ad;
    src = (md == 2'd0) ? od : (md == 2'd3) ? rget(k) : mem[mi];
    sec = (md == 2'd3) ? mem[mi] : rget(k);
    case (oc[7:5])
      3'd0: res = {1'b0, src};
      3'd1: res = {1'b0, sec} + src;
      3'd2: res = {1'b0, sec} - src;
      3'd3: res = {1'b0, sec & src};
      3'd4: res = {1'b0, sec | src};
      default: res = {1'b0, sec ^ src};
    endcase
    if (oc[7:5] < 3'd6) begin
      if (md == 2'd3) mem[mi] = res[7:0];
      else if (k == 2'd0) a = res[7:0];
      else if (k == 2'd1) x = res[7:0];
      else if (k == 2'd2) s = res[7:0];
      else f = (f & 8'hE8) | (res[7:0] & `CPUOA_F_WMASK);
      if (oc[7:5] != 3'd0 && !(md == 2'd0 && k == 2'd3)) begin
        f[`CPUOA_F_ZERO] = (res[7:0] == 8'h00);
        f[`CPUOA_F_CARRY] = res[8];
      end
    end
    pc = pc + `CPUOA_INSTR_LEN;
    apb(1'b1, `CPUOA_OFS_INSTR, {16'h0, oc, od}, 32'h0, 1'b0);
    do begin
      @(posedge pclk);
    end while (busy !== 1'b0);
    regs();
  endtask

  // ****************************************************************
  // Result watcher and stimulus
  // ****************************************************************
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        t = q.pop_front();
        check(prdata & t.m, t.d);
        check({31'h0, pslverr}, {31'h0, t.e});
      end
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {a, x, s, pc} = '0;
    f = 8'h02;
    void'($urandom(28));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    regs();
    foreach (prog[i]) run(prog[i][15:8], prog[i][7:0]);
    run(8'hC0, 8'h00);
    run(8'hE7, 8'h55);
    apb(1'b0, `CPUOA_OFS_STATUS, 32'h2, 32'hFFFFFFFF, 1'b0);
    apb(1'b1, `CPUOA_OFS_STATUS, 32'h2, 32'h0, 1'b0);
    apb(1'b0, `CPUOA_OFS_STATUS, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, `CPUOA_OFS_INSTR, 32'hE755, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, 12'h040, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 12'h044, 32'h5A, 32'h0, 1'b1);
    // Enough instructions to carry into the high byte
    repeat (120) begin
      r = 2'($urandom % 4);
      run({3'($urandom % (r == 2'd3 ? 6 : 3)), 3'b000, r},
          8'($urandom));
    end
    // Mid-run reset: counter and working registers restart
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    {a, x, s, pc} = '0;
    f = `CPUOA_RST_FLAGS;
    regs();
    run(8'h01, 8'h3C);
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule
